// ### core/ambient_threshold_params.svh
// Constants for the ambient light threshold window register bank.
// Included by the bank and its expander; definitions only.
`ifndef AMBIENT_THRESHOLD_PARAMS_SVH
`define AMBIENT_THRESHOLD_PARAMS_SVH

// Byte register offsets on the device register port
`define AMB_OFS_LOWER_LO    8'h0B
`define AMB_OFS_LOWER_HI    8'h0C
`define AMB_OFS_UPPER_LO    8'h0D
`define AMB_OFS_UPPER_HI    8'h0E

// Reset value of every threshold byte
`define AMB_RESET_BYTE      8'h00
`define AMB_RESET_WORD      16'h0000

// Field positions of the compressed code
`define AMB_CODE_EXP_MSB    7
`define AMB_CODE_EXP_LSB    4
`define AMB_CODE_MANT_MSB   3
`define AMB_CODE_MANT_LSB   0
`define AMB_CODE_FRAC_BITS  4

`endif

// ### core/ambient_threshold_pkg.sv
// Types shared by the ambient light threshold window bank.
// Constants live in ambient_threshold_params.svh.
`default_nettype none

package ambient_threshold_pkg;

    typedef logic [7:0]  byte_type;
    typedef logic [15:0] threshold_type;

    typedef enum logic
    {
        CHANNEL_VISIBLE  = 1'b0,
        CHANNEL_INFRARED = 1'b1
    } channel_type;

endpackage

`default_nettype wire

// ### core/threshold_expand_if.sv
// Carries one compressed threshold code to the expander and back.
// Used only between the bank and its expander instances.
`timescale 1ns/100ps
`default_nettype none

interface threshold_expand_if;
    ambient_threshold_pkg::byte_type      compressedCode;
    ambient_threshold_pkg::threshold_type expandedValue;

    modport source   (output compressedCode, input  expandedValue);
    modport expander (input  compressedCode, output expandedValue);
endinterface

`default_nettype wire

// ### core/threshold_expander.sv
// Expands an 8-bit compressed threshold to a 16-bit value.
// Pure combinational; code is exponent in the high nibble, fraction low.
`timescale 1ns/100ps
`default_nettype none
`include "ambient_threshold_params.svh"

module threshold_expander
(
    // Compressed code in, full value out
    threshold_expand_if.expander port
);

    logic [4:0]  mantissa;
    logic [19:0] shifted;

    always_comb
    begin
        mantissa = {1'b1, port.compressedCode[`AMB_CODE_MANT_MSB:`AMB_CODE_MANT_LSB]};
        shifted  = {15'h0000, mantissa} << port.compressedCode[`AMB_CODE_EXP_MSB:`AMB_CODE_EXP_LSB];
        // Code zero means a true zero, not the smallest nonzero step
        if (port.compressedCode == `AMB_RESET_BYTE)
        begin
            port.expandedValue = `AMB_RESET_WORD;
        end
        else
        begin
            port.expandedValue = shifted[19:`AMB_CODE_FRAC_BITS];
        end
    end

endmodule

`default_nettype wire

// ### core/ambient_light_threshold_window.sv
// Ambient light threshold window: four byte registers forming a lower and
// an upper 16-bit bound, and the window compare that flags the host.
// Assumes a serial-bus slave in front drives the byte register port and
// the measurement sequencer presents results with a one-cycle valid.
`timescale 1ns/100ps
`default_nettype none
`include "ambient_threshold_params.svh"

module ambient_light_threshold_window
#(
    // Revision from which the upper low byte exists (arbitrary value)
    parameter logic [7:0] MIN_UPPER_LO_REV = 8'h40
)
(
    // Clock and reset
    input  wire logic                               clock,
    input  wire logic                               reset,
    // Straps, caught once after reset release
    input  wire logic                               compressedStrap,
    input  wire logic [7:0]                         sequencerRevision,
    // Byte register port from the serial-bus slave
    input  wire logic [7:0]                         regAddr,
    input  wire ambient_threshold_pkg::byte_type    regWrData,
    input  wire logic                               regWrite,
    input  wire logic                               regRead,
    output logic [7:0]                              regRdData_ff,
    // Measurement results from the sequencer
    input  wire logic                               autonomousActive,
    input  wire ambient_threshold_pkg::channel_type channelSelect,
    input  wire ambient_threshold_pkg::threshold_type visibleResult,
    input  wire ambient_threshold_pkg::threshold_type infraredResult,
    input  wire logic                               resultValid,
    // Interrupt request toward the interrupt status logic
    output logic                                    ambientIrq_ff
);

    ////////////////////////////////////////////////////////////////////////
    // Strap capture

    logic       strapsTaken_ff;
    logic       nxt_strapsTaken;
    logic       compressedMode_ff;
    logic       nxt_compressedMode;
    logic       upperLoPresent_ff;
    logic       nxt_upperLoPresent;

    always_comb
    begin
        nxt_strapsTaken    = 1'b1;
        nxt_compressedMode = compressedMode_ff;
        nxt_upperLoPresent = upperLoPresent_ff;
        if (!strapsTaken_ff)
        begin
            nxt_compressedMode = compressedStrap;
            nxt_upperLoPresent = (sequencerRevision >= MIN_UPPER_LO_REV);
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            strapsTaken_ff    <= 1'b0;
            compressedMode_ff <= 1'b0;
            upperLoPresent_ff <= 1'b0;
        end
        else
        begin
            strapsTaken_ff    <= nxt_strapsTaken;
            compressedMode_ff <= nxt_compressedMode;
            upperLoPresent_ff <= nxt_upperLoPresent;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold registers

    ambient_threshold_pkg::threshold_type lowerBound_ff;
    ambient_threshold_pkg::threshold_type nxt_lowerBound;
    ambient_threshold_pkg::threshold_type upperBound_ff;
    ambient_threshold_pkg::threshold_type nxt_upperBound;
    logic [7:0]                           nxt_regRdData;

    always_comb
    begin
        nxt_lowerBound = lowerBound_ff;
        nxt_upperBound = upperBound_ff;
        nxt_regRdData  = regRdData_ff;
        if (regWrite)
        begin
            unique case (regAddr)
                `AMB_OFS_LOWER_LO: nxt_lowerBound[7:0]  = regWrData;
                `AMB_OFS_LOWER_HI: nxt_lowerBound[15:8] = regWrData;
                `AMB_OFS_UPPER_LO:
                begin
                    if (upperLoPresent_ff)
                    begin
                        nxt_upperBound[7:0] = regWrData;
                    end
                end
                `AMB_OFS_UPPER_HI: nxt_upperBound[15:8] = regWrData;
                default:           nxt_lowerBound = lowerBound_ff;
            endcase
        end
        if (regRead)
        begin
            unique case (regAddr)
                `AMB_OFS_LOWER_LO: nxt_regRdData = lowerBound_ff[7:0];
                `AMB_OFS_LOWER_HI: nxt_regRdData = lowerBound_ff[15:8];
                `AMB_OFS_UPPER_LO: nxt_regRdData = upperLoPresent_ff ? upperBound_ff[7:0]
                                                                     : `AMB_RESET_BYTE;
                `AMB_OFS_UPPER_HI: nxt_regRdData = upperBound_ff[15:8];
                default:           nxt_regRdData = `AMB_RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            lowerBound_ff <= `AMB_RESET_WORD;
            upperBound_ff <= `AMB_RESET_WORD;
            regRdData_ff  <= `AMB_RESET_BYTE;
        end
        else
        begin
            lowerBound_ff <= nxt_lowerBound;
            upperBound_ff <= nxt_upperBound;
            regRdData_ff  <= nxt_regRdData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective bounds; compressed code sits in each low byte

    threshold_expand_if lowerExpand ();
    threshold_expand_if upperExpand ();

    assign lowerExpand.compressedCode = lowerBound_ff[7:0];
    assign upperExpand.compressedCode = upperBound_ff[7:0];

    threshold_expander lowerExpander
    (
        .port (lowerExpand.expander)
    );

    threshold_expander upperExpander
    (
        .port (upperExpand.expander)
    );

    ambient_threshold_pkg::threshold_type effLower;
    ambient_threshold_pkg::threshold_type effUpper;
    ambient_threshold_pkg::threshold_type selResult;
    logic                                 outsideWindow;
    logic                                 nxt_ambientIrq;

    always_comb
    begin
        effLower = compressedMode_ff ? lowerExpand.expandedValue : lowerBound_ff;
        effUpper = compressedMode_ff ? upperExpand.expandedValue : upperBound_ff;
        selResult = (channelSelect == ambient_threshold_pkg::CHANNEL_INFRARED)
                    ? infraredResult : visibleResult;
        // Bounds are inclusive: a result equal to a bound is inside
        outsideWindow  = (selResult < effLower) || (selResult > effUpper);
        nxt_ambientIrq = autonomousActive && resultValid && outsideWindow;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            ambientIrq_ff <= 1'b0;
        end
        else
        begin
            ambientIrq_ff <= nxt_ambientIrq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_LOWER_LO_WRITE: assert property (@(posedge clock) disable iff (reset)
        regWrite && regAddr == `AMB_OFS_LOWER_LO |=> lowerBound_ff[7:0] == $past(regWrData))
        else $error("Lower low byte not stored");

    AST_UPPER_HI_WRITE: assert property (@(posedge clock) disable iff (reset)
        regWrite && regAddr == `AMB_OFS_UPPER_HI |=> upperBound_ff[15:8] == $past(regWrData))
        else $error("Upper high byte not stored");

    AST_WRITE_READBACK: assert property (@(posedge clock) disable iff (reset)
        regWrite && regAddr == `AMB_OFS_LOWER_HI ##1 !regWrite
        ##1 regRead && regAddr == `AMB_OFS_LOWER_HI && !regWrite
        |=> regRdData_ff == $past(regWrData, 3))
        else $error("Lower high byte read back wrong");

    AST_RESET_ZERO: assert property (@(posedge clock)
        $fell(reset) |-> lowerBound_ff == `AMB_RESET_WORD && upperBound_ff == `AMB_RESET_WORD)
        else $error("Bounds not zero after reset");

    AST_IRQ_OUTSIDE: assert property (@(posedge clock) disable iff (reset)
        autonomousActive && resultValid && selResult > effUpper |=> ambientIrq_ff)
        else $error("No interrupt above upper bound");

    AST_NO_IRQ_INSIDE: assert property (@(posedge clock) disable iff (reset)
        ambientIrq_ff |-> $past(resultValid) && $past(autonomousActive)
        && ($past(selResult) < $past(effLower) || $past(selResult) > $past(effUpper)))
        else $error("Interrupt without outside result");

    AST_COMPRESSED_EXPAND: assert property (@(posedge clock) disable iff (reset)
        compressedMode_ff && lowerBound_ff[7:0] == 8'h69 |-> effLower == 16'h0064)
        else $error("Compressed bound expanded wrong");

    AST_UPPER_LO_ABSENT: assert property (@(posedge clock) disable iff (reset)
        strapsTaken_ff && !upperLoPresent_ff && regWrite && regAddr == `AMB_OFS_UPPER_LO
        |=> upperBound_ff[7:0] == $past(upperBound_ff[7:0]))
        else $error("Absent upper low byte was written");

    COV_IRQ: cover property (@(posedge clock) disable iff (reset) ambientIrq_ff);
    COV_INFRARED_IRQ: cover property (@(posedge clock) disable iff (reset)
        channelSelect == ambient_threshold_pkg::CHANNEL_INFRARED && nxt_ambientIrq);
    COV_COMPRESSED: cover property (@(posedge clock) disable iff (reset)
        compressedMode_ff && resultValid && autonomousActive);
    COV_READ_UPPER: cover property (@(posedge clock) disable iff (reset)
        regRead && regAddr == `AMB_OFS_UPPER_LO);

endmodule

`default_nettype wire

// ### testbench/host_port_model.sv
// Host side of the byte register port: strobed byte reads and writes.
// Assumes the bench clock; requests change on the falling edge only.
`timescale 1ns/100ps
`default_nettype none

module host_port_model
(
    // Clock
    input  wire logic                       clock,
    // Byte register port
    output logic [7:0]                      regAddr,
    output ambient_threshold_pkg::byte_type regWrData,
    output logic                            regWrite,
    output logic                            regRead,
    input  wire logic [7:0]                 regRdData_ff
);
    initial
    begin
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(negedge clock);
        regAddr = addr;
        regWrData = data;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        // Released data shows the inverse, not a stale copy
        regWrData = ~data;
    endtask

    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clock);
        regAddr = addr;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        data = regRdData_ff;
    endtask
endmodule

`default_nettype wire

// ### testbench/ambient_light_threshold_window_bench.sv
// Self-checking bench for the ambient threshold window register bank.
// Assumes the host port model drives the register port.
`timescale 1ns/100ps
`default_nettype none

module ambient_light_threshold_window_bench;
    logic                                 clock;
    logic                                 reset;
    logic                                 compressedStrap;
    logic [7:0]                           sequencerRevision;
    logic [7:0]                           regAddr;
    ambient_threshold_pkg::byte_type      regWrData;
    logic                                 regWrite;
    logic                                 regRead;
    logic [7:0]                           regRdData_ff;
    logic                                 autonomousActive;
    ambient_threshold_pkg::channel_type   channelSelect;
    ambient_threshold_pkg::threshold_type visibleResult;
    ambient_threshold_pkg::threshold_type infraredResult;
    logic                                 resultValid;
    logic                                 ambientIrq_ff;
    int                                   n_errors;
    int                                   num_checks;
    logic [7:0]                           rd;
    logic [7:0]                           wrTable [5] = '{8'h80, 8'h01, 8'hC0, 8'h02, 8'h5A};
    logic [7:0]                           rdTable [5] = '{8'h80, 8'h01, 8'hC0, 8'h02, 8'h00};
    logic [15:0]                          valTable [4] = '{16'h017F, 16'h0180, 16'h02C0, 16'h02C1};
    logic                                 irqTable [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    always #5 clock = ~clock;

    ambient_light_threshold_window u_ambient_light_threshold_window
    (
        .clock(clock), .reset(reset), .compressedStrap(compressedStrap),
        .sequencerRevision(sequencerRevision), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData_ff(regRdData_ff),
        .autonomousActive(autonomousActive), .channelSelect(channelSelect),
        .visibleResult(visibleResult), .infraredResult(infraredResult),
        .resultValid(resultValid), .ambientIrq_ff(ambientIrq_ff)
    );

    host_port_model u_host_port_model
    (
        .clock(clock), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
        .regRead(regRead), .regRdData_ff(regRdData_ff)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic apply_reset(input logic comp, input logic [7:0] rev);
        reset = 1'b1;
        compressedStrap = comp;
        sequencerRevision = rev;
        repeat (12) @(negedge clock);
        reset = 1'b0;
        repeat (2) @(negedge clock);
    endtask

    task automatic expect_reg(input logic [7:0] addr, input logic [7:0] exp);
        u_host_port_model.read_byte(addr, rd);
        check("register byte", {8'h00, rd}, {8'h00, exp});
    endtask

    // Other channel carries the inverse so a wrong channel choice shows
    task automatic measure(input logic ch, input logic [15:0] value, input logic act,
                           input logic expIrq);
        @(negedge clock);
        channelSelect = ambient_threshold_pkg::channel_type'(ch);
        visibleResult = ch ? ~value : value;
        infraredResult = ch ? value : ~value;
        autonomousActive = act;
        resultValid = 1'b1;
        @(negedge clock);
        resultValid = 1'b0;
        check("interrupt", {15'h0000, ambientIrq_ff}, {15'h0000, expIrq});
        @(negedge clock);
        check("interrupt end", {15'h0000, ambientIrq_ff}, 16'h0000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5000) @(posedge clock);
        n_errors++;
        complete_run();
    end

    initial
    begin
        clock = 1'b0;
        autonomousActive = 1'b0;
        channelSelect = ambient_threshold_pkg::CHANNEL_VISIBLE;
        visibleResult = 16'h0000;
        infraredResult = 16'h0000;
        resultValid = 1'b0;
        n_errors = 0;
        num_checks = 0;
        apply_reset(1'b0, 8'h40);
        for (int i = 0; i < 5; i++)
            expect_reg(8'h0B + i[7:0], 8'h00);
        $display("test reset_values done");
        // Measurements halted while bounds change
        autonomousActive = 1'b0;
        for (int i = 0; i < 5; i++)
            u_host_port_model.write_byte(8'h0B + i[7:0], wrTable[i]);
        for (int i = 0; i < 5; i++)
            expect_reg(8'h0B + i[7:0], rdTable[i]);
        $display("test byte_placement done");
        for (int c = 0; c < 2; c++)
            for (int i = 0; i < 4; i++)
                measure(c[0], valTable[i], 1'b1, irqTable[i]);
        measure(1'b0, 16'h0000, 1'b0, 1'b0);
        $display("test window_compare done");
        // Write then read one byte, one idle cycle between
        u_host_port_model.write_byte(8'h0C, 8'h3C);
        expect_reg(8'h0C, 8'h3C);
        apply_reset(1'b1, 8'h40);
        expect_reg(8'h0B, 8'h00);
        u_host_port_model.write_byte(8'h0B, 8'h69);
        u_host_port_model.write_byte(8'h0D, 8'h84);
        measure(1'b0, 16'h0063, 1'b1, 1'b1);
        measure(1'b0, 16'h0064, 1'b1, 1'b0);
        measure(1'b1, 16'h0140, 1'b1, 1'b0);
        measure(1'b1, 16'h0141, 1'b1, 1'b1);
        $display("test compressed_bounds done");
        apply_reset(1'b0, 8'h3F);
        u_host_port_model.write_byte(8'h0D, 8'h55);
        u_host_port_model.write_byte(8'h0E, 8'h66);
        expect_reg(8'h0D, 8'h00);
        expect_reg(8'h0E, 8'h66);
        $display("test early_revision done");
        complete_run();
    end
endmodule

`default_nettype wire
